// [hdl/osf_pkg.sv]
package osf_pkg;

	// ------------------------------------------------------------------
	// Frame layout, byte positions within one 2064-byte frame.
	// ------------------------------------------------------------------
	localparam logic [11:0] POS_PRESET = 12'h003;
	localparam logic [11:0] POS_RSV    = 12'h006;
	localparam logic [11:0] POS_PAY    = 12'h00C;
	localparam logic [11:0] POS_EDC    = 12'h80C;
	localparam logic [11:0] POS_LAST   = 12'h80F;

	// ------------------------------------------------------------------
	// Code block geometry.
	// ------------------------------------------------------------------
	localparam logic [7:0]  COL_DATA_LAST = 8'hAB;
	localparam logic [7:0]  COL_LAST      = 8'hB5;
	localparam logic [7:0]  COLS          = 8'hB6;
	localparam logic [7:0]  ROW_DATA_LAST = 8'hBF;
	localparam logic [7:0]  ROW_PO0       = 8'hC0;
	localparam logic [7:0]  ROW_LAST      = 8'hCF;
	localparam logic [7:0]  ROWS_PER_FRM  = 8'h0C;
	localparam logic [3:0]  RROW_LAST     = 4'hC;
	localparam logic [3:0]  FRM_LAST      = 4'hF;
	localparam logic [3:0]  PO_LAST       = 4'hF;
	localparam logic [3:0]  PI_LAST       = 4'h9;
	localparam int          N_PO          = 16;
	localparam int          N_PI          = 10;
	localparam int          BLK_BYTES     = 37856;

	// ------------------------------------------------------------------
	// Polynomials and modulation constants.
	// ------------------------------------------------------------------
	localparam logic [31:0] EDC_POLY    = 32'h80000011;
	localparam logic [7:0]  GF_POLY     = 8'h1D;
	localparam logic [7:0]  SUBST_LIMIT = 8'h58;
	localparam logic [3:0]  CW_LAST     = 4'hF;

	// Multiply in GF(256) reduced by the primitive polynomial.
	function automatic logic [7:0] gf_mul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i])
				p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
		end
		return p;
	endfunction

	// Generator polynomial coefficients, low order in the low byte.
	function automatic logic [127:0] rs_gen(input int n);
		logic [7:0]   g [0:16];
		logic [7:0]   a;
		logic [127:0] r;
		for (int i = 0; i <= 16; i++)
			g[i] = 8'h00;
		g[0] = 8'h01;
		a = 8'h01;
		r = 128'h0;
		for (int k = 0; k < n; k++) begin
			for (int i = 16; i > 0; i--)
				g[i] = g[i-1] ^ gf_mul(g[i], a);
			g[0] = gf_mul(g[0], a);
			a = gf_mul(a, 8'h02);
		end
		for (int i = 0; i < 16; i++)
			r[8*i +: 8] = g[i];
		return r;
	endfunction

	// One byte of the frame check, most significant bit first.
	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[31] ^ d[i];
			r = {r[30:0], 1'b0} ^ (fb ? EDC_POLY : 32'h0);
		end
		return r;
	endfunction

	// Eight shifts of the scrambler, stage 14 xor stage 10 into stage 0.
	function automatic logic [14:0] scr8(input logic [14:0] s);
		logic [14:0] r;
		r = s;
		for (int i = 0; i < 8; i++)
			r = {r[13:0], r[14] ^ r[10]};
		return r;
	endfunction

	// Scrambler preset per index.
	function automatic logic [14:0] scr_preset(input logic [3:0] i);
		unique case (i)
			4'h0: return 15'h0001;
			4'h1: return 15'h5500;
			4'h2: return 15'h0002;
			4'h3: return 15'h2A00;
			4'h4: return 15'h0004;
			4'h5: return 15'h5400;
			4'h6: return 15'h0008;
			4'h7: return 15'h2800;
			4'h8: return 15'h0010;
			4'h9: return 15'h5000;
			4'hA: return 15'h0020;
			4'hB: return 15'h2001;
			4'hC: return 15'h0040;
			4'hD: return 15'h4002;
			4'hE: return 15'h0080;
			4'hF: return 15'h0005;
		endcase
	endfunction

endpackage

// [hdl/osf_rs_enc.sv]
`timescale 1ns/10ps

// Systematic Reed-Solomon parity generator, one symbol per cycle.
module osf_rs_enc #(
	parameter int NPAR = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              clr,
	input  wire logic              en,
	input  wire logic [7:0]        din,
	output logic      [8*NPAR-1:0] parity
);

	localparam logic [127:0] GEN = osf_pkg::rs_gen(NPAR);

	logic [7:0] par_q [0:NPAR-1];
	logic [7:0] fb;

	// Feedback is the incoming symbol plus the highest parity stage.
	assign fb = din ^ par_q[NPAR-1];

	// ------------------------------------------------------------------
	// Division stages, one per parity symbol.
	// ------------------------------------------------------------------
	for (genvar k = 0; k < NPAR; k++) begin : g_stage
		always_ff @(posedge ref_clk) begin
			if (reset || clr)
				par_q[k] <= 8'h00;
			else if (en)
				par_q[k] <= (k == 0 ? 8'h00 : par_q[(k == 0) ? 0 : k-1])
					^ osf_pkg::gf_mul(fb, GEN[8*k +: 8]);
		end
		assign parity[8*k +: 8] = par_q[k];
	end

endmodule // osf_rs_enc

// [hdl/osf_modulator.sv]
`timescale 1ns/10ps

// Byte to 16-bit code word through an external table, then NRZI.
module osf_modulator (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic             byte_ready,
	input  wire logic        subst_en,
	output logic      [7:0]  tbl_byte,
	output logic      [1:0]  tbl_state,
	output logic             tbl_subst,
	input  wire logic [15:0] tbl_code,
	input  wire logic [1:0]  tbl_next,
	output logic             chan_bit,
	output logic             chan_strobe
);

	typedef enum logic [1:0] {M_IDLE, M_LOOK, M_SHIFT} osf_mst_e;

	osf_mst_e    mst_q;
	logic [3:0]  cnt_q;
	logic [15:0] sh_q;
	logic        take;

	assign take = byte_valid && byte_ready;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------------
	// Sequencing: take, look up, then shift sixteen channel bits.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mst_q      <= M_IDLE;
			byte_ready <= 1'b0;
			cnt_q      <= 4'h0;
		end else begin
			unique case (mst_q)
				M_IDLE: begin
					byte_ready <= !take;
					if (take)
						mst_q <= M_LOOK;
				end
				M_LOOK: begin
					cnt_q <= 4'h0;
					mst_q <= M_SHIFT;
				end
				M_SHIFT: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == osf_pkg::CW_LAST) begin
						mst_q      <= M_IDLE;
						byte_ready <= 1'b1;
					end
				end
			endcase
		end
	end

	// Table address is held stable from the take until the next take.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tbl_byte  <= 8'h00;
			tbl_subst <= 1'b0;
		end else if (take) begin
			tbl_byte  <= byte_data;
			tbl_subst <= subst_en && byte_data < osf_pkg::SUBST_LIMIT;
		end
	end

	// The entry's next state governs the following byte.
	always_ff @(posedge ref_clk) begin
		if (reset)
			tbl_state <= 2'h0;
		else if (mst_q == M_LOOK)
			tbl_state <= tbl_next;
	end

	// Word register, most significant bit leaves first.
	always_ff @(posedge ref_clk) begin
		if (reset)
			sh_q <= 16'h0000;
		else if (mst_q == M_LOOK)
			sh_q <= tbl_code;
		else if (mst_q == M_SHIFT)
			sh_q <= {sh_q[14:0], 1'b0};
	end

	// A one flips the written level, a zero keeps it.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			chan_bit    <= 1'b0;
			chan_strobe <= 1'b0;
		end else begin
			chan_strobe <= mst_q == M_SHIFT;
			if (mst_q == M_SHIFT)
				chan_bit <= chan_bit ^ sh_q[15];
		end
	end

	sequence s_burst;
		chan_strobe [*8] ##1 chan_strobe [*8] ##1 !chan_strobe;
	endsequence

	chk_nrzi_toggle: assert property (
		chan_strobe |-> chan_bit == ($past(chan_bit) ^ $past(sh_q[15])))
		else $error("channel level does not follow the code word");

	chk_word_burst: assert property (
		take |=> !chan_strobe ##1 !chan_strobe ##1 s_burst)
		else $error("code word is not sixteen consecutive bits");

	chk_state_next: assert property (
		mst_q == M_LOOK |=> tbl_state == $past(tbl_next))
		else $error("encoder state not taken from table entry");

endmodule // osf_modulator

// [hdl/osf_formatter.sv]
`timescale 1ns/10ps

// Contract
// - Six application bytes are zero unless the application supplies them.
// - Four check bytes close each frame, covering the 2060 bytes before.
// - Check input is taken most significant bit of the first byte first.
// - Check value is the remainder modulo x^32 + x^31 + x^4 + 1.
// - Only the 2048 payload bytes are scrambled, one byte per eight shifts.
// - Scrambler stages are preset at each frame start from the preset table.
// - Preset index is identifier bits seven down to four.
// - Sixteen fixed preset values, one per index.
// - First mask is the preset's low byte; each next after eight shifts.
// - Sixteen scrambled frames fill a 192 by 172 byte block.
// - Each column gets 16 outer parity bytes in rows 192 to 207.
// - Each row gets 10 inner parity bytes in columns 172 to 181.
// - Inner parity follows outer parity and covers all 208 rows.
// - All parity arithmetic uses GF(256) with x^8+x^4+x^3+x^2+1.
// - Data row i goes to i+i/12; parity row i to 13(i-191)-1.
// - The block leaves as 16 frames of 13 rows by 182 bytes.
// - Each byte becomes a 16-bit run-length-limited code word.
// - A four-valued encoder state picks the word and is set by it.
// - Code words leave NRZI coded, a one toggling the level.
// - First sector number of each block must be a multiple of 16.
module osf_formatter (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_data,
	output logic             in_ready,
	input  wire logic        app_rsv_en,
	input  wire logic [47:0] app_rsv,
	input  wire logic        subst_en,
	output logic      [7:0]  tbl_byte,
	output logic      [1:0]  tbl_state,
	output logic             tbl_subst,
	input  wire logic [15:0] tbl_code,
	input  wire logic [1:0]  tbl_next,
	output logic             chan_bit,
	output logic             chan_strobe,
	output logic             align_err
);

	typedef enum logic [2:0] {
		S_IN, S_OUT, S_OUT_WR, S_INN, S_INN_WR, S_EMIT
	} osf_st_e;

	osf_st_e      st_q;
	logic [11:0]  pos_q;
	logic [7:0]   row_q;
	logic [7:0]   col_q;
	logic [3:0]   k_q;
	logic [3:0]   frm_q;
	logic [3:0]   rrow_q;
	logic [31:0]  crc_q;
	logic [14:0]  scr_q;
	logic [7:0]   blk_mem [0:osf_pkg::BLK_BYTES-1];

	logic         host_pos;
	logic         pay_pos;
	logic         take;
	logic         gen;
	logic         adv;
	logic         in_last;
	logic [7:0]   src_byte;
	logic [7:0]   wr_byte;
	logic [7:0]   mem_row;
	logic [7:0]   mem_col;
	logic [15:0]  mem_addr;
	logic         mem_we;
	logic [7:0]   mem_wd;
	logic [7:0]   mem_rd;
	logic [127:0] po_par;
	logic [79:0]  pi_par;
	logic         emit_take;
	logic         emit_last;
	logic         mod_ready;
	logic [11:0]  pos_nx;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------------
	// Intake: host bytes, inserted application bytes, check bytes.
	// ------------------------------------------------------------------
	assign host_pos = pos_q < osf_pkg::POS_RSV
		|| (pos_q >= osf_pkg::POS_PAY && pos_q < osf_pkg::POS_EDC);
	assign pay_pos  = pos_q >= osf_pkg::POS_PAY
		&& pos_q < osf_pkg::POS_EDC;
	assign take     = st_q == S_IN && host_pos && in_valid && in_ready;
	assign gen      = st_q == S_IN && !host_pos;
	assign adv      = take || gen;
	assign in_last  = adv && pos_q == osf_pkg::POS_LAST
		&& frm_q == osf_pkg::FRM_LAST;
	assign pos_nx   = (pos_q == osf_pkg::POS_LAST) ? 12'h000
		: pos_q + 12'h001;

	// Unscrambled byte of the frame at the current position.
	always_comb begin
		if (host_pos)
			src_byte = in_data;
		else if (pos_q < osf_pkg::POS_PAY)
			src_byte = app_rsv_en ? app_rsv[8*(11-32'(pos_q)) +: 8]
				: 8'h00;
		else
			src_byte = crc_q[8*(2063-32'(pos_q)) +: 8];
	end

	// Payload is masked by the running scrambler byte, header is not.
	assign wr_byte = pay_pos ? src_byte ^ scr_q[7:0] : src_byte;

	// The check restarts at each frame's first byte and sees plain data.
	always_ff @(posedge ref_clk) begin
		if (reset)
			crc_q <= 32'h0;
		else if (adv && pos_q < osf_pkg::POS_EDC)
			crc_q <= osf_pkg::crc_byte(
				(pos_q == 12'h000) ? 32'h0 : crc_q, src_byte);
	end

	// Preset is loaded once the identifier's low byte has arrived.
	always_ff @(posedge ref_clk) begin
		if (reset)
			scr_q <= 15'h0;
		else if (take && pos_q == osf_pkg::POS_PRESET)
			scr_q <= osf_pkg::scr_preset(in_data[7:4]);
		else if (take && pay_pos)
			scr_q <= osf_pkg::scr8(scr_q);
	end

	// Alignment of the block's first sector number is flagged, not fixed.
	always_ff @(posedge ref_clk) begin
		if (reset)
			align_err <= 1'b0;
		else if (take && frm_q == 4'h0 && pos_q == osf_pkg::POS_PRESET)
			align_err <= in_data[3:0] != 4'h0;
	end

	// Ready is registered, so it looks ahead to the next position.
	always_ff @(posedge ref_clk) begin
		if (reset)
			in_ready <= 1'b0;
		else if (st_q == S_IN && !in_last)
			in_ready <= adv ? (pos_nx < osf_pkg::POS_RSV
				|| (pos_nx >= osf_pkg::POS_PAY
				&& pos_nx < osf_pkg::POS_EDC)) : host_pos;
		else
			in_ready <= st_q == S_EMIT && emit_last; // Low through parity.
	end

	// ------------------------------------------------------------------
	// Block store, addressed by row and column in every phase.
	// ------------------------------------------------------------------
	always_comb begin
		mem_row = row_q;
		mem_col = col_q;
		mem_we  = 1'b0;
		mem_wd  = wr_byte;
		unique case (st_q)
			S_IN:
				mem_we = adv;
			S_OUT_WR: begin
				mem_row = osf_pkg::ROW_PO0 + {4'h0, k_q};
				mem_we  = 1'b1;
				mem_wd  = po_par[8*(15-32'(k_q)) +: 8];
			end
			S_INN_WR: begin
				mem_col = osf_pkg::COL_DATA_LAST + 8'h01 + {4'h0, k_q};
				mem_we  = 1'b1;
				mem_wd  = pi_par[8*(9-32'(k_q)) +: 8];
			end
			S_EMIT:
				mem_row = (rrow_q == osf_pkg::RROW_LAST)
					? osf_pkg::ROW_PO0 + {4'h0, frm_q}
					: 8'({4'h0, frm_q} * osf_pkg::ROWS_PER_FRM)
					+ {4'h0, rrow_q};
			default: ;
		endcase
	end

	assign mem_addr = 16'(16'(mem_row) * 16'(osf_pkg::COLS))
		+ 16'(mem_col);
	assign mem_rd   = blk_mem[mem_addr];

	// Asynchronous read keeps the column walks one symbol per cycle.
	always_ff @(posedge ref_clk) begin
		if (mem_we)
			blk_mem[mem_addr] <= mem_wd;
	end

	// ------------------------------------------------------------------
	// Parity generators over GF(256).
	// ------------------------------------------------------------------
	osf_rs_enc #(.NPAR(osf_pkg::N_PO)) u_outer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clr     (st_q == S_OUT_WR && k_q == osf_pkg::PO_LAST),
		.en      (st_q == S_OUT),
		.din     (mem_rd),
		.parity  (po_par)
	);

	osf_rs_enc #(.NPAR(osf_pkg::N_PI)) u_inner (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clr     (st_q == S_INN_WR && k_q == osf_pkg::PI_LAST),
		.en      (st_q == S_INN),
		.din     (mem_rd),
		.parity  (pi_par)
	);

	// ------------------------------------------------------------------
	// Phase sequencer and block counters.
	// ------------------------------------------------------------------
	assign emit_take = st_q == S_EMIT && mod_ready;
	assign emit_last = emit_take && col_q == osf_pkg::COL_LAST
		&& rrow_q == osf_pkg::RROW_LAST && frm_q == osf_pkg::FRM_LAST;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q   <= S_IN;
			pos_q  <= 12'h000;
			row_q  <= 8'h00;
			col_q  <= 8'h00;
			k_q    <= 4'h0;
			frm_q  <= 4'h0;
			rrow_q <= 4'h0;
		end else begin
			unique case (st_q)
				S_IN: if (adv) begin
					pos_q <= pos_nx;
					col_q <= (col_q == osf_pkg::COL_DATA_LAST) ? 8'h00
						: col_q + 8'h01;
					if (col_q == osf_pkg::COL_DATA_LAST)
						row_q <= row_q + 8'h01;
					if (pos_q == osf_pkg::POS_LAST)
						frm_q <= frm_q + 4'h1;
					if (in_last) begin
						st_q  <= S_OUT;
						row_q <= 8'h00;
						col_q <= 8'h00;
					end
				end
				S_OUT: begin
					row_q <= row_q + 8'h01;
					k_q   <= 4'h0;
					if (row_q == osf_pkg::ROW_DATA_LAST)
						st_q <= S_OUT_WR;
				end
				S_OUT_WR: begin
					k_q <= k_q + 4'h1;
					if (k_q == osf_pkg::PO_LAST) begin
						row_q <= 8'h00;
						col_q <= (col_q == osf_pkg::COL_DATA_LAST) ? 8'h00
							: col_q + 8'h01;
						st_q  <= (col_q == osf_pkg::COL_DATA_LAST) ? S_INN
							: S_OUT;
					end
				end
				S_INN: begin
					col_q <= col_q + 8'h01;
					k_q   <= 4'h0;
					if (col_q == osf_pkg::COL_DATA_LAST)
						st_q <= S_INN_WR;
				end
				S_INN_WR: begin
					k_q <= k_q + 4'h1;
					if (k_q == osf_pkg::PI_LAST) begin
						col_q <= 8'h00;
						row_q <= (row_q == osf_pkg::ROW_LAST) ? 8'h00
							: row_q + 8'h01;
						st_q  <= (row_q == osf_pkg::ROW_LAST) ? S_EMIT
							: S_INN;
					end
				end
				S_EMIT: if (emit_take) begin
					col_q <= (col_q == osf_pkg::COL_LAST) ? 8'h00
						: col_q + 8'h01;
					if (col_q == osf_pkg::COL_LAST) begin
						rrow_q <= (rrow_q == osf_pkg::RROW_LAST) ? 4'h0
							: rrow_q + 4'h1;
						if (rrow_q == osf_pkg::RROW_LAST)
							frm_q <= frm_q + 4'h1;
					end
					if (emit_last) begin
						st_q  <= S_IN;
						pos_q <= 12'h000;
						row_q <= 8'h00;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Modulation of the recording frames.
	// ------------------------------------------------------------------
	osf_modulator u_mod (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.byte_valid  (st_q == S_EMIT),
		.byte_data   (mem_rd),
		.byte_ready  (mod_ready),
		.subst_en    (subst_en),
		.tbl_byte    (tbl_byte),
		.tbl_state   (tbl_state),
		.tbl_subst   (tbl_subst),
		.tbl_code    (tbl_code),
		.tbl_next    (tbl_next),
		.chan_bit    (chan_bit),
		.chan_strobe (chan_strobe)
	);

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	sequence s_rsv_slot;
		gen && pos_q >= osf_pkg::POS_RSV && pos_q < osf_pkg::POS_PAY;
	endsequence

	chk_rsv_zero: assert property (
		s_rsv_slot and !app_rsv_en |-> mem_we && mem_wd == 8'h00)
		else $error("application field not zero by default");

	chk_edc_first: assert property (
		gen && pos_q == osf_pkg::POS_EDC |-> mem_wd == crc_q[31:24]
			&& $past(crc_q) != crc_q
			|| $past(pos_q) != osf_pkg::POS_EDC - 12'h001)
		else $error("check byte does not follow the payload");

	chk_crc_restart: assert property (
		take && pos_q == 12'h000 |=>
			crc_q == osf_pkg::crc_byte(32'h0, $past(in_data)))
		else $error("check did not restart at frame start");

	chk_scr_preset: assert property (
		take && pos_q == osf_pkg::POS_PRESET |=>
			scr_q == osf_pkg::scr_preset($past(in_data[7:4])))
		else $error("scrambler preset not from identifier");

	chk_header_plain: assert property (
		take && pos_q < osf_pkg::POS_RSV |-> mem_wd == in_data)
		else $error("header byte was altered");

	chk_gen_stall: assert property (
		gen |-> !in_ready)
		else $error("ready high during an inserted byte");

	chk_outer_len: assert property (
		$rose(st_q == S_OUT_WR) |-> $past(row_q) == osf_pkg::ROW_DATA_LAST)
		else $error("outer parity after wrong row count");

	chk_inner_rows: assert property (
		$rose(st_q == S_EMIT) |-> $past(row_q) == osf_pkg::ROW_LAST
			&& $past(k_q) == osf_pkg::PI_LAST)
		else $error("inner parity did not cover all rows");

	chk_il_parity: assert property (
		st_q == S_EMIT && rrow_q == osf_pkg::RROW_LAST |->
			mem_row == osf_pkg::ROW_PO0 + {4'h0, frm_q})
		else $error("parity row misplaced in recording frame");

endmodule // osf_formatter

// [tb/osf_host_model.sv]
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Host byte source and code word lookup for the formatter.
// ------------------------------------------------------------------
module osf_host_model (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        go,
	output logic             in_valid,
	output logic      [7:0]  in_data,
	input  wire logic        in_ready,
	input  wire logic [7:0]  tbl_byte,
	input  wire logic        tbl_subst,
	output logic      [15:0] tbl_code,
	output logic      [1:0]  tbl_next
);
	int n_q;
	int n_d;

	// Byte at stream position n: sector 0x000050 plus frame, fixed check.
	function automatic logic [7:0] src_byte(input int n);
		int f;
		int k;
		f = n / 2054;
		k = n % 2054;
		if (k < 3)
			return 8'h00;
		if (k == 3)
			return 8'h50 + f[7:0];
		if (k == 4)
			return 8'hAA;
		if (k == 5)
			return 8'h55;
		return k[7:0] - 8'h06;
	endfunction

	// Next stream position, counting a byte only when it is taken.
	always_comb begin
		n_d = (in_valid && in_ready) ? n_q + 1 : n_q;
	end

	// The offer is held until the edge where in_ready is seen high.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			n_q <= 0;
			in_valid <= 1'b0;
			in_data <= 8'h00;
		end else begin
			n_q <= n_d;
			in_valid <= go && (n_d < 16 * 2054);
			in_data <= src_byte(n_d);
		end
	end

	// Behavioural table; it does not obey run length limits.
	assign tbl_code = {tbl_byte ^ {7'h00, tbl_subst}, ~tbl_byte};
	assign tbl_next = tbl_byte[1:0];
endmodule // osf_host_model

// [tb/osf_formatter_bench.sv]
`timescale 1ns/10ps

module osf_formatter_bench;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        go = 1'b0;
	logic        in_valid;
	logic [7:0]  in_data;
	logic        in_ready;
	logic [7:0]  tbl_byte;
	logic [1:0]  tbl_state;
	logic        tbl_subst;
	logic [15:0] tbl_code;
	logic [1:0]  tbl_next;
	logic        chan_bit;
	logic        chan_strobe;
	logic        align_err;
	int          num_errors = 0;
	int          compares = 0;
	logic [7:0]  head [12] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'hAA, 8'h55,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ------------------------------------------------------------------
	// Clock, design and partner.
	// ------------------------------------------------------------------
	always #20 ref_clk = ~ref_clk;

	osf_formatter DUT (.ref_clk(ref_clk), .reset(reset), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready), .app_rsv_en(1'b0),
		.app_rsv(48'h123456789ABC), .subst_en(1'b1), .tbl_byte(tbl_byte),
		.tbl_state(tbl_state), .tbl_subst(tbl_subst), .tbl_code(tbl_code),
		.tbl_next(tbl_next), .chan_bit(chan_bit),
		.chan_strobe(chan_strobe), .align_err(align_err));

	osf_host_model host (.ref_clk(ref_clk), .reset(reset), .go(go),
		.in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.tbl_byte(tbl_byte), .tbl_subst(tbl_subst), .tbl_code(tbl_code),
		.tbl_next(tbl_next));

	// ------------------------------------------------------------------
	// Compare tasks and the closing task.
	// ------------------------------------------------------------------
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic stop_test;
		$display("Compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// A block takes about 107k cycles before its first byte leaves.
	initial begin
		repeat (130000) @(posedge ref_clk);
		num_errors++;
		$display("Watchdog expired at %0t", $time);
		stop_test();
	end

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		logic [14:0] scr;
		logic [7:0]  exp;
		logic [15:0] word;
		logic [1:0]  st;
		logic        lvl;
		scr = 15'h5400;
		st = 2'h0;
		lvl = 1'b0;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		check1(in_ready, 1'b0);
		check1(chan_strobe, 1'b0);
		check1(chan_bit, 1'b0);
		check1(align_err, 1'b0);
		check8({6'h00, tbl_state}, 8'h00);
		$display("Reset test done");
		@(posedge ref_clk);
		go <= 1'b1;
		// One pass per emitted byte of the 172 data bytes of the first recording row.
		for (int i = 0; i < 172; i++) begin
			if (i < 12) begin
				exp = head[i];
			end else begin
				exp = 8'(i - 12) ^ scr[7:0];
				for (int s = 0; s < 8; s++)
					scr = {scr[13:0], scr[14] ^ scr[10]};
			end
			while (chan_strobe !== 1'b1)
				@(negedge ref_clk);
			check8(tbl_byte, exp);
			check1(tbl_subst, exp < 8'h58);
			word = {exp ^ {7'h00, exp < 8'h58}, ~exp};
			check8({6'h00, tbl_state}, {6'h00, exp[1:0]});
			for (int b = 15; b >= 0; b--) begin
				lvl = lvl ^ word[b];
				check1(chan_strobe, 1'b1);
				check1(chan_bit, lvl);
				@(negedge ref_clk);
			end
			check1(chan_strobe, 1'b0);
			st = exp[1:0];
		end
		$display("Emission test done, last state %h", st);
		check1(align_err, 1'b0);
		$display("Alignment test done");
		stop_test();
	end
endmodule // osf_formatter_bench
